// ---- core/see_engine.sv ----
// How it works
// - Command bits shift into an 8-bit register on serial clock rises.
// - Every byte moves most significant bit first, both directions.
// - First command bit is the first clock rise after select falls.
// - Hold low freezes the transfer; release resumes exactly where paused.
// - Read command plus address shifts the stored byte out.
// - Read pointer advances by one after each byte sent.
// - Read pointer wraps from top address to bottom.
// - Select rising ends a read.
// - Latch set takes effect only at the select rise ending its frame.
// - Array write is command, address, data, after latch set frame.
// - Up to 16 data bytes per write, all in one page.
// - Write address wraps within the page, overwriting earlier bytes.
// - Select rising mid-byte aborts the write, array untouched.
// - Status reads work during a write cycle; array reads are refused.
// - Write enable latch clears when the write cycle finishes.
// - Read decodes as 0000x011, write as 0000x010.
// - Latch set decodes as 0000x110, latch clear as 0000x100.
// - Status read decodes as 0000x101, status write as 0000x001.
// - Internal write lasts the fixed cycle time from the select rise.
// - Latch clears at reset, clear, status or array write, protect pin low.
// - Status bit 0 busy, bit 1 latch, bits 2 and 3 protect.
// - Protect pair selects none, top quarter, top half or all.
// - Pin low or latch clear blocks array and status writes.
`include "see_regs.svh"
`default_nettype none

module see_fifo #(
  parameter int WIDTH = `SEE_FIFO_WIDTH,
  parameter int DEPTH = `SEE_FIFO_DEPTH
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData,
  // Level flags
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wrPtrReg, wrPtrNext, rdPtrReg, rdPtrNext;
  logic [AW:0]      countReg, countNext;
  logic             push, pop;

  // Flags and handshakes
  assign inReady  = countReg != (AW + 1)'(DEPTH);
  assign empty    = countReg == '0;
  assign outValid = !empty;
  assign outData  = store[rdPtrReg];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Pointer and count update
  always_comb begin
    wrPtrNext = push ? AW'(wrPtrReg + 1'b1) : wrPtrReg;
    rdPtrNext = pop ? AW'(rdPtrReg + 1'b1) : rdPtrReg;
    countNext = countReg;
    if (push && !pop) begin
      countNext = (AW + 1)'(countReg + 1'b1);
    end else if (pop && !push) begin
      countNext = (AW + 1)'(countReg - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      countReg <= '0;
    end else if (ce) begin
      wrPtrReg <= wrPtrNext;
      rdPtrReg <= rdPtrNext;
      countReg <= countNext;
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (ce && push) begin
      store[wrPtrReg] <= inData;
    end
  end
endmodule // see_fifo

module see_engine #(
  parameter int WRITE_CYCLES = `SEE_TWC_MS * (`SEE_CLK_HZ / 1000),
  parameter int PROG_PACE    = `SEE_PROG_PACE
) (
  // Clock and control
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  // Serial pins
  input  wire logic csN,
  input  wire logic sck,
  input  wire logic si,
  input  wire logic holdN,
  input  wire logic wpN,
  output logic      soOut,
  output logic      soOe,
  // Status
  output logic      writeInProgress,
  output logic      writeEnableLatch,
  output logic      blockProtectLo,
  output logic      blockProtectHi
);
  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam int PW = $clog2(PROG_PACE + 1);
  localparam logic [4:0] PIN_RST = `SEE_PIN_RST; // Idle pin levels, one bit per synchroniser

  logic [7:0]  memArr [256];
  logic [7:0]  pageData [16];
  logic [4:0]  pinRaw, sync1Reg, sync2Reg;
  logic        sckPrevReg, csPrevReg;
  logic        csS, sckS, siS, holdS, wpS, active, sckRise, sckFall, csRise, byteDone;
  logic [7:0]  rxFull;
  see_pkg::see_state_type stateReg, stateNext;
  logic [2:0]  bitCntReg, bitCntNext;
  logic [7:0]  rxReg, rxNext, txReg, txNext, ptrReg, ptrNext;
  logic        soOutReg, soOutNext, soOeReg, soOeNext, welReg, welNext;
  logic        soLiveReg, soLiveNext;
  logic [1:0]  bpReg, bpNext, stPendReg, stPendNext;
  logic        byteSeenReg, byteSeenNext, startReg, startNext, startArrReg, startArrNext;
  logic [15:0] pageValidReg, pageValidNext;
  logic        busyReg, busyNext, cycleDoneReg, cycleDoneNext;
  logic [TW-1:0] timerReg, timerNext;
  logic [4:0]  feedIdxReg, feedIdxNext;
  logic [PW-1:0] paceReg, paceNext;
  logic        fifoInValid, fifoInReady, fifoOutValid, fifoEmpty, drainReady, pageWr;
  logic [15:0] fifoOutData;

  // Protected range lookup
  function automatic logic isProtected(input logic [1:0] bp, input logic [7:0] addr);
    if (bp == `SEE_BP_NONE) begin
      return 1'b0;
    end else if (bp == `SEE_BP_QTR) begin
      return addr >= `SEE_QTR_BASE;
    end else if (bp == `SEE_BP_HALF) begin
      return addr >= `SEE_HALF_BASE;
    end else begin
      return 1'b1;
    end
  endfunction

  // Status byte layout
  function automatic logic [7:0] statusByte(input logic [1:0] bp, input logic write_enable_latch, input logic busy);
    logic [7:0] s;
    s = 8'h00;
    s[`SEE_ST_WIP]   = busy;
    s[`SEE_ST_WEL]   = write_enable_latch;
    s[`SEE_ST_BP_LO] = bp[0];
    s[`SEE_ST_BP_HI] = bp[1];
    return s;
  endfunction

  // Two-stage pin synchronisers
  assign pinRaw = {csN, sck, si, holdN, wpN};
  for (genvar i = 0; i < 5; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (reset) begin
        sync1Reg[i] <= PIN_RST[i];
        sync2Reg[i] <= PIN_RST[i];
      end else if (ce) begin
        sync1Reg[i] <= pinRaw[i];
        sync2Reg[i] <= sync1Reg[i];
      end
    end
  end

  // Edge detection on synced pins
  assign {csS, sckS, siS, holdS, wpS} = sync2Reg;
  assign active   = !csS && holdS;
  assign sckRise  = active && sckS && !sckPrevReg;
  assign sckFall  = active && !sckS && sckPrevReg;
  assign csRise   = csS && !csPrevReg;
  assign rxFull   = {rxReg[6:0], siS};
  assign byteDone = sckRise && bitCntReg == 3'h7;
  assign pageWr   = byteDone && stateReg == see_pkg::ST_WDATA;

  always_ff @(posedge clk) begin
    if (reset) begin
      sckPrevReg <= 1'b0;
      csPrevReg  <= 1'b1;
    end else if (ce) begin
      sckPrevReg <= sckS;
      csPrevReg  <= csS;
    end
  end

  // Frame sequencer next state
  always_comb begin
    stateNext = stateReg;  bitCntNext = bitCntReg;  rxNext = rxReg;
    txNext = txReg;  ptrNext = ptrReg;  soOutNext = soOutReg;
    welNext = welReg;  bpNext = bpReg;  stPendNext = stPendReg;
    byteSeenNext = byteSeenReg;  startNext = 1'b0;  startArrNext = startArrReg;
    pageValidNext = pageValidReg;
    if (cycleDoneNext) begin
      welNext = 1'b0;
    end
    if (csS) begin
      stateNext  = see_pkg::ST_IDLE;
      bitCntNext = 3'h0;
      if (csRise && bitCntReg == 3'h0) begin
        case (stateReg)
          see_pkg::ST_LSET: welNext = 1'b1;
          see_pkg::ST_LCLR: welNext = 1'b0;
          see_pkg::ST_SWDONE: begin
            if (welReg && wpS) begin
              bpNext       = stPendReg;
              startNext    = 1'b1;
              startArrNext = 1'b0;
            end
          end
          see_pkg::ST_WDATA: begin
            if (byteSeenReg && welReg && wpS) begin
              startNext    = 1'b1;
              startArrNext = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end else begin
      if (stateReg == see_pkg::ST_IDLE) begin
        stateNext = see_pkg::ST_CMD;
      end
      if (sckRise) begin
        bitCntNext = 3'(bitCntReg + 3'h1);
        rxNext     = rxFull;
      end
      if (byteDone) begin
        case (stateReg)
          see_pkg::ST_CMD: begin
            if (rxFull[7:4] != `SEE_OP_HI || (busyReg && rxFull[2:0] != `SEE_OP_SRD)) begin
              stateNext = see_pkg::ST_IGNORE;
            end else if (rxFull[2:0] == `SEE_OP_READ) begin
              stateNext = see_pkg::ST_RADDR;
            end else if (rxFull[2:0] == `SEE_OP_WRITE) begin
              stateNext     = see_pkg::ST_WADDR;
              byteSeenNext  = 1'b0;
              pageValidNext = 16'h0000;
            end else if (rxFull[2:0] == `SEE_OP_LSET) begin
              stateNext = see_pkg::ST_LSET;
            end else if (rxFull[2:0] == `SEE_OP_LCLR) begin
              stateNext = see_pkg::ST_LCLR;
            end else if (rxFull[2:0] == `SEE_OP_SRD) begin
              stateNext = see_pkg::ST_SRD;
              txNext    = statusByte(bpReg, welReg, busyReg);
            end else if (rxFull[2:0] == `SEE_OP_SWR) begin
              stateNext = see_pkg::ST_SWR;
            end else begin
              stateNext = see_pkg::ST_IGNORE;
            end
          end
          see_pkg::ST_RADDR: begin
            stateNext = see_pkg::ST_RDATA;
            ptrNext   = rxFull;
            txNext    = memArr[rxFull];
          end
          see_pkg::ST_RDATA: begin
            ptrNext = 8'(ptrReg + 8'h01);
            txNext  = memArr[8'(ptrReg + 8'h01)];
          end
          see_pkg::ST_WADDR: begin
            stateNext = see_pkg::ST_WDATA;
            ptrNext   = rxFull;
          end
          see_pkg::ST_WDATA: begin
            pageValidNext[ptrReg[3:0]] = !isProtected(bpReg, ptrReg);
            ptrNext      = {ptrReg[7:4], 4'(ptrReg[3:0] + 4'h1)};
            byteSeenNext = 1'b1;
          end
          see_pkg::ST_SWR: begin
            stateNext  = see_pkg::ST_SWDONE;
            stPendNext = {rxFull[`SEE_ST_BP_HI], rxFull[`SEE_ST_BP_LO]};
          end
          see_pkg::ST_SRD: txNext = statusByte(bpReg, welReg, busyReg);
          default: ;
        endcase
      end
      if (sckFall && (stateReg == see_pkg::ST_RDATA || stateReg == see_pkg::ST_SRD)) begin
        soOutNext = txReg[3'h7 - bitCntReg];
      end
    end
    // Output phase survives a hold so the held bit comes back on release
    soLiveNext = !csS && (stateReg == see_pkg::ST_RDATA || stateReg == see_pkg::ST_SRD) &&
                 (soLiveReg || sckFall);
    soOeNext   = active && soLiveNext;
    if (!wpS) begin
      welNext = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stateReg <= see_pkg::ST_IDLE;  bitCntReg <= 3'h0;  rxReg <= 8'h00;
      txReg <= 8'h00;  ptrReg <= 8'h00;  soOutReg <= 1'b0;  soOeReg <= 1'b0;
      welReg <= 1'b0;  bpReg <= `SEE_BP_RST;  stPendReg <= 2'h0;
      byteSeenReg <= 1'b0;  startReg <= 1'b0;  startArrReg <= 1'b0;
      pageValidReg <= 16'h0000;
      soLiveReg <= 1'b0;
    end else if (ce) begin
      stateReg <= stateNext;  bitCntReg <= bitCntNext;  rxReg <= rxNext;
      txReg <= txNext;  ptrReg <= ptrNext;  soOutReg <= soOutNext;  soOeReg <= soOeNext;
      welReg <= welNext;  bpReg <= bpNext;  stPendReg <= stPendNext;
      byteSeenReg <= byteSeenNext;  startReg <= startNext;  startArrReg <= startArrNext;
      pageValidReg <= pageValidNext;
      soLiveReg <= soLiveNext;
    end
  end

  // Page buffer data
  always_ff @(posedge clk) begin
    if (ce && pageWr) begin
      pageData[ptrReg[3:0]] <= rxFull;
    end
  end

  // Write cycle engine next state
  assign fifoInValid = busyReg && !feedIdxReg[4] && pageValidReg[feedIdxReg[3:0]];
  assign drainReady  = paceReg == '0;
  always_comb begin
    busyNext = busyReg;  timerNext = timerReg;  feedIdxNext = feedIdxReg;
    cycleDoneNext = 1'b0;
    paceNext = drainReady ? PW'(PROG_PACE) : PW'(paceReg - 1'b1);
    if (startReg) begin
      busyNext    = 1'b1;
      timerNext   = '0;
      feedIdxNext = startArrReg ? 5'h00 : `SEE_PAGE_BYTES;
    end else if (busyReg) begin
      if (timerReg != TW'(WRITE_CYCLES)) begin
        timerNext = TW'(timerReg + 1'b1);
      end
      if (!feedIdxReg[4] && (!fifoInValid || fifoInReady)) begin
        feedIdxNext = 5'(feedIdxReg + 5'h01);
      end
      if (timerReg == TW'(WRITE_CYCLES) && feedIdxReg[4] && fifoEmpty) begin
        busyNext      = 1'b0;
        cycleDoneNext = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      busyReg <= 1'b0;  timerReg <= '0;  feedIdxReg <= `SEE_PAGE_BYTES;
      cycleDoneReg <= 1'b0;  paceReg <= '0;
    end else if (ce) begin
      busyReg <= busyNext;  timerReg <= timerNext;  feedIdxReg <= feedIdxNext;
      cycleDoneReg <= cycleDoneNext;  paceReg <= paceNext;
    end
  end

  // Paced programming queue into the array
  see_fifo #(.WIDTH(`SEE_FIFO_WIDTH), .DEPTH(`SEE_FIFO_DEPTH)) u_fifo (
    .clk(clk), .reset(reset), .ce(ce),
    .inValid(fifoInValid), .inReady(fifoInReady),
    .inData({ptrReg[7:4], feedIdxReg[3:0], pageData[feedIdxReg[3:0]]}),
    .outValid(fifoOutValid), .outReady(drainReady), .outData(fifoOutData), .empty(fifoEmpty)
  );

  always_ff @(posedge clk) begin
    if (ce && fifoOutValid && drainReady) begin
      memArr[fifoOutData[15:8]] <= fifoOutData[7:0];
    end
  end

  // Outputs
  assign soOut            = soOutReg;
  assign soOe             = soOeReg;
  assign writeInProgress  = busyReg;
  assign writeEnableLatch = welReg;
  assign blockProtectLo   = bpReg[0];
  assign blockProtectHi   = bpReg[1];

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_SO_QUIET: assert property (ce && (csS || !holdS) |=> !soOe)
    else $error("serial output driven while deselected or held");
  AST_HOLD_FREEZE: assert property (ce && !csS && !holdS |=> $stable(bitCntReg) && $stable(rxReg))
    else $error("frame state moved while held");
  AST_WP_CLEARS: assert property (ce && !wpS |=> !welReg)
    else $error("latch not cleared by protect pin");
  AST_READ_STEP: assert property (ce && byteDone && stateReg == see_pkg::ST_RDATA
    |=> ptrReg == 8'($past(ptrReg) + 8'h01))
    else $error("read pointer did not advance");
  AST_READ_WRAP: assert property (ce && byteDone && stateReg == see_pkg::ST_RDATA && ptrReg == 8'hFF
    |=> ptrReg == 8'h00)
    else $error("read pointer did not wrap");
  AST_PAGE_STAY: assert property (ce && pageWr |=> ptrReg[7:4] == $past(ptrReg[7:4]))
    else $error("write crossed page");
  AST_BUSY_REFUSE: assert property (ce && byteDone && stateReg == see_pkg::ST_CMD && busyReg &&
    rxFull[2:0] == `SEE_OP_READ |=> stateReg == see_pkg::ST_IGNORE)
    else $error("array read accepted while busy");
  AST_LATCH_AUTOCLR: assert property ($fell(busyReg) |-> !welReg)
    else $error("latch still set after write cycle");
  AST_SET_AT_RISE: assert property ($rose(welReg) |-> $past(csRise))
    else $error("latch set without select rise");
  AST_ABORT: assert property (ce && csRise && stateReg == see_pkg::ST_WDATA && bitCntReg != 3'h0
    && !busyReg |=> ##1 !busyReg)
    else $error("partial byte started a write");
  AST_TIMER: assert property (ce && startReg |=> busyReg && timerReg == '0)
    else $error("write cycle timer not started");
  COV_READ_WRAP: cover property (byteDone && stateReg == see_pkg::ST_RDATA && ptrReg == 8'hFF);
  COV_COMMIT: cover property (startReg && startArrReg);
  COV_STATUS_BUSY: cover property (byteDone && stateReg == see_pkg::ST_SRD && busyReg);
  COV_CYCLE_END: cover property (cycleDoneReg && !welReg);
endmodule // see_engine
`default_nettype wire

// ---- shared/see_regs.svh ----
`ifndef SEE_REGS_SVH
`define SEE_REGS_SVH
// Opcode low bits, bit 3 ignored, bits 7:4 must be zero
`define SEE_OP_HI        4'h0
`define SEE_OP_SWR       3'h1
`define SEE_OP_WRITE     3'h2
`define SEE_OP_READ      3'h3
`define SEE_OP_LCLR      3'h4
`define SEE_OP_SRD       3'h5
`define SEE_OP_LSET      3'h6
// Status byte field positions
`define SEE_ST_WIP       0
`define SEE_ST_WEL       1
`define SEE_ST_BP_LO     2
`define SEE_ST_BP_HI     3
// Block protect codes and range bases
`define SEE_BP_NONE      2'h0
`define SEE_BP_QTR       2'h1
`define SEE_BP_HALF      2'h2
`define SEE_QTR_BASE     8'hC0
`define SEE_HALF_BASE    8'h80
`define SEE_BP_RST       2'h0
// Pin sync reset levels {cs, sck, si, hold, wp}
`define SEE_PIN_RST      5'h13
// Timing
`define SEE_CLK_HZ       100000000
`define SEE_TWC_MS       5
`define SEE_PROG_PACE    4
`define SEE_PAGE_BYTES   5'h10
`define SEE_FIFO_DEPTH   8
`define SEE_FIFO_WIDTH   16
`endif

// ---- shared/see_pkg.sv ----
`default_nettype none
package see_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_RADDR, ST_RDATA, ST_WADDR, ST_WDATA,
    ST_SRD, ST_SWR, ST_SWDONE, ST_LSET, ST_LCLR, ST_IGNORE
  } see_state_type;
endpackage
`default_nettype wire

// ---- dv/see_host_model.sv ----
`default_nettype none
// Host side of the serial link: mode 0, one byte at a time
module see_host_model #(
  parameter int HALF = 8
) (
  // Clock
  input  wire logic       clk,
  // Serial pins
  output logic            csN,
  output logic            sck,
  output logic            si,
  output logic            holdN,
  input  wire logic       soOut,
  input  wire logic       soOe,
  // Checked byte
  output logic            rxStrobe,
  output logic [7:0]      rxByte
);
  logic       lastSo;
  logic       soLine;
  logic       oeSeen;
  logic       holdOe;
  int         nbits;

  // Released line shows a pattern that flips every cycle
  assign soLine = soOe ? soOut : ~lastSo;
  always @(posedge clk) begin
    lastSo <= soLine;
  end

  // Idle pin levels at time zero
  initial begin
    lastSo = 1'b0;
    csN = 1'b1;
    sck = 1'b0; // Clock stands still outside frames
    si = 1'b0;
    holdN = 1'b1;
    rxStrobe = 1'b0;
    rxByte = 8'h00;
    oeSeen = 1'b0;
    holdOe = 1'b1;
    nbits = 8;
  end

  // Select low opens a frame
  task automatic open_frame();
    @(posedge clk);
    csN <= 1'b0;
    oeSeen = 1'b0;
    repeat (HALF) @(posedge clk);
  endtask

  // Select high after a full low phase
  task automatic close_frame();
    repeat (HALF) @(posedge clk);
    csN <= 1'b1;
    repeat (HALF) @(posedge clk);
  endtask

  // Up to one byte each way, sampled before each rise
  task automatic xfer(input logic [7:0] tx, input bit chk, input bit pause, output logic [7:0] rx);
    for (int i = 7; i > 7 - nbits; i--) begin
      si <= tx[i];
      repeat (HALF) @(posedge clk);
      rx[i] = soLine;
      oeSeen = oeSeen | soOe;
      sck <= 1'b1;
      repeat (HALF) @(posedge clk);
      sck <= 1'b0;
      if (pause && i == 4) begin
        // Hold goes low only once the clock has stood low for a while
        repeat (HALF) @(posedge clk);
        holdN <= 1'b0;
        repeat (HALF) @(posedge clk);
        holdOe = soOe;
        repeat (2) begin
          sck <= 1'b1;
          si <= ~si;
          repeat (HALF) @(posedge clk);
          sck <= 1'b0;
          repeat (HALF) @(posedge clk);
        end
        holdN <= 1'b1;
      end
    end
    if (chk) begin
      rxByte <= rx;
      rxStrobe <= 1'b1;
      @(posedge clk);
      rxStrobe <= 1'b0;
    end
  endtask
endmodule // see_host_model
`default_nettype wire

// ---- dv/see_engine_tb_top.sv ----
`default_nettype none
// Self-checking bench for the serial EEPROM engine
module see_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WC = 1200;
  logic            clk, reset, ce, wpN;
  wire logic       csN, sck, si, holdN, soOut, soOe, rxStrobe;
  wire logic       write_in_progress, write_enable_latch, bpLo, bpHi;
  wire logic [7:0] rxByte;
  logic [7:0]      mem [256];
  logic [7:0]      expQ [$];
  logic [7:0]      pa [3] = '{8'h40, 8'h90, 8'hD0};
  logic [7:0]      r;
  logic [1:0]      bp;
  int              failures, testsRun;

  see_engine #(.WRITE_CYCLES(WC), .PROG_PACE(4)) dut (.clk(clk), .reset(reset), .ce(ce), .csN(csN),
    .sck(sck), .si(si), .holdN(holdN), .wpN(wpN), .soOut(soOut), .soOe(soOe), .writeInProgress(write_in_progress),
    .writeEnableLatch(write_enable_latch), .blockProtectLo(bpLo), .blockProtectHi(bpHi));
  see_host_model host (.clk(clk), .csN(csN), .sck(sck), .si(si), .holdN(holdN), .soOut(soOut),
    .soOe(soOe), .rxStrobe(rxStrobe), .rxByte(rxByte));

  // 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    testsRun++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Oldest note against each received byte
  always @(posedge clk) begin
    if (rxStrobe === 1'b1) begin
      if (expQ.size() == 0) chk("unnoted byte", 8'h00, rxByte);
      else chk("read byte", expQ.pop_front(), rxByte);
    end
  end

  function automatic bit prot(input logic [7:0] a);
    return bp == 2'h3 || (bp == 2'h2 && a[7]) || (bp == 2'h1 && a[7:6] == 2'h3);
  endfunction

  task automatic cmd(input logic [7:0] op);
    logic [7:0] q;
    host.open_frame();
    host.xfer(op, 0, 0, q);
    host.close_frame();
  endtask

  // Bounded wait on the busy bit
  task automatic wait_idle();
    int n;
    n = 0;
    while (write_in_progress !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > WC + 100) begin
        failures++;
        test_done();
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] op, input bit w);
    logic [7:0] q, d;
    cmd(8'h06);
    host.open_frame();
    host.xfer(op, 0, 0, q);
    host.xfer(a, 0, 0, q);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      host.xfer(d, 0, 0, q);
      if (!prot(a)) mem[a] = d;
      a[3:0] = a[3:0] + 4'h1;
    end
    host.close_frame();
    if (w) begin
      wait_idle();
      chk("latch after write", 8'h00, {7'h00, write_enable_latch});
    end
  endtask

  task automatic rd(input logic [7:0] a, input int n, input bit p, input logic [7:0] op);
    logic [7:0] q;
    host.open_frame();
    host.xfer(op, 0, 0, q);
    host.xfer(a, 0, 0, q);
    for (int i = 0; i < n; i++) begin
      expQ.push_back(mem[a]);
      host.xfer(8'h00, 1, p && i == 1, q);
      a = a + 8'h01;
    end
    host.close_frame();
  endtask

  task automatic sq(input logic [7:0] e);
    logic [7:0] q;
    host.open_frame();
    host.xfer(8'h0D, 0, 0, q);
    repeat (2) begin
      expQ.push_back(e);
      host.xfer(8'h00, 1, 0, q);
    end
    host.close_frame();
  endtask

  task automatic swr(input logic [1:0] v);
    logic [7:0] q;
    cmd(8'h06);
    host.open_frame();
    host.xfer(8'h01, 0, 0, q);
    host.xfer({4'h0, v, 2'h0}, 0, 0, q);
    host.close_frame();
    wait_idle();
    bp = v;
    chk("protect bits", {6'h00, v}, {6'h00, bpHi, bpLo});
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    wpN = 1'b1;
    bp = 2'h0;
    failures = 0;
    testsRun = 0;
    void'($urandom(88));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    chk("status after reset", 8'h00, {4'h0, bpHi, bpLo, write_enable_latch, write_in_progress});
    cmd(8'h0E);
    chk("latch set", 8'h01, {7'h00, write_enable_latch});
    // A whole frame sent while the clock enable is low is never seen
    ce <= 1'b0;
    cmd(8'h0C);
    ce <= 1'b1;
    chk("frozen clear", 8'h01, {7'h00, write_enable_latch});
    cmd(8'h14);
    chk("odd opcode", 8'h01, {7'h00, write_enable_latch});
    sq(8'h02);
    cmd(8'h0C);
    chk("latch clear", 8'h00, {7'h00, write_enable_latch});
    cmd(8'h06);
    wpN <= 1'b0;
    repeat (6) @(posedge clk);
    chk("latch pin low", 8'h00, {7'h00, write_enable_latch});
    host.open_frame();
    host.xfer(8'h01, 0, 0, r);
    host.xfer(8'h0C, 0, 0, r);
    host.close_frame();
    chk("status blocked", 8'h00, {5'h00, bpHi, bpLo, write_in_progress});
    wpN <= 1'b1;
    $display("test latch done");
    for (int v = 0; v < 4; v++) begin
      swr(2'(v));
      foreach (pa[j]) wr(pa[j], 1, 8'h02, 1);
      foreach (pa[j]) rd(pa[j], 1, 0, 8'h03);
    end
    swr(2'h0);
    $display("test protect done");
    wr(8'h1E, 18, 8'h0A, 1);
    rd(8'h10, 16, 0, 8'h03);
    wr(8'hFE, 2, 8'h02, 1);
    wr(8'h00, 2, 8'h02, 1);
    rd(8'hFE, 4, 1, 8'h0B);
    chk("out during hold", 8'h00, {7'h00, host.holdOe});
    $display("test read done");
    wr(8'h20, 1, 8'h02, 0);
    sq(8'h03);
    host.open_frame();
    host.xfer(8'h03, 0, 0, r);
    host.xfer(8'h20, 0, 0, r);
    host.xfer(8'h00, 0, 0, r);
    host.close_frame();
    chk("read in busy", 8'h00, {7'h00, host.oeSeen});
    wait_idle();
    chk("latch after cycle", 8'h00, {7'h00, write_enable_latch});
    cmd(8'h06);
    host.open_frame();
    host.xfer(8'h02, 0, 0, r);
    host.xfer(8'h20, 0, 0, r);
    host.nbits = 4;
    host.xfer(8'hA5, 0, 0, r);
    host.nbits = 8;
    host.close_frame();
    chk("cut write busy", 8'h00, {7'h00, write_in_progress});
    chk("cut frame latch", 8'h01, {7'h00, write_enable_latch});
    host.open_frame();
    host.xfer(8'h12, 0, 0, r);
    host.xfer(8'h20, 0, 0, r);
    host.xfer(8'h5A, 0, 0, r);
    host.close_frame();
    chk("bad opcode busy", 8'h00, {7'h00, write_in_progress});
    rd(8'h20, 1, 0, 8'h03);
    $display("test abort done");
    // Full page through the programming queue, polled, then read back
    wr(8'h30, 16, 8'h02, 0);
    chk("busy after page", 8'h01, {7'h00, write_in_progress});
    sq(8'h03);
    wait_idle();
    chk("latch after page", 8'h00, {7'h00, write_enable_latch});
    chk("protect after page", 8'h00, {6'h00, bpHi, bpLo});
    chk("idle after page", 8'h00, {7'h00, write_in_progress});
    rd(8'h30, 16, 0, 8'h03);
    $display("test page done");
    repeat (4) @(posedge clk);
    chk("notes left", 8'h00, 8'(expQ.size()));
    test_done();
  end
endmodule // see_engine_tb_top
`default_nettype wire
